/* File: verilog/cptc_pkg.sv */
package cptc_pkg;

    // Register byte offsets
    localparam logic [3:0] CTRL_OFS    = 4'h0;
    localparam logic [3:0] DELAY_OFS   = 4'h4;
    localparam logic [3:0] PULSE_OFS   = 4'h8;
    localparam logic [3:0] STATUS_OFS  = 4'hC;

    // Control field positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_STOP_BIT  = 1;
    localparam int CTRL_SENSE_BIT = 2;
    localparam int CTRL_GATE_LSB  = 4;
    localparam int CTRL_TB_LSB    = 8;

    // Reset values
    localparam logic [23:0] DELAY_RST = 24'h000003;
    localparam logic [23:0] PULSE_RST = 24'h000003;

    // Gate usage modes
    typedef enum logic [2:0] {
        GATE_IGNORED   = 3'h0,
        GATE_HIGH_LVL  = 3'h1,
        GATE_LOW_LVL   = 3'h2,
        GATE_RISE_TRIG = 3'h3,
        GATE_FALL_TRIG = 3'h4
    } cptc_gate_t;

    // Run states, Gray coded along idle -> arm -> delay -> pulse
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARM   = 2'b01,
        ST_DELAY = 2'b11,
        ST_PULSE = 2'b10
    } cptc_state_t;

endpackage

/* File: verilog/cptc_tick_if.sv */
`timescale 1ns/1ps
interface cptc_tick_if;
    logic [2:0] select;
    logic       run;
    logic       tick;
    modport source (input select, input run, output tick);
    modport sink   (output select, output run, input tick);
endinterface

/* File: verilog/cptc_timebase.sv */
`timescale 1ns/1ps
// Timebase prescaler: tick every 10**select clocks for select 0 to 6; select 7 ticks every 10**6 clocks like 6
module cptc_timebase (
    // Clock and reset
    input wire logic     clock,
    input wire logic     reset,
    // Timebase link
    cptc_tick_if.source  tb
);
    logic [19:0] cnt_r;
    logic [19:0] limit;
    logic        tick_r;

    always_comb begin
        case (tb.select)
            3'h0:    limit = 20'h00000;
            3'h1:    limit = 20'h00009;
            3'h2:    limit = 20'h00063;
            3'h3:    limit = 20'h003E7;
            3'h4:    limit = 20'h0270F;
            3'h5:    limit = 20'h1869F;
            default: limit = 20'hF423F;
        endcase
    end

    // Restart on stop so the first phase is full length
    always_ff @(posedge clock) begin
        if (reset || !tb.run) begin
            cnt_r  <= 20'h00000;
            tick_r <= 1'b0;
        end else if (cnt_r >= limit) begin
            cnt_r  <= 20'h00000;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 20'h00001;
            tick_r <= 1'b0;
        end
    end

    assign tb.tick = tick_r;
endmodule

/* File: verilog/cptc_top.sv */
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - Runs forever after start until stop
// - Loads delay count, then pulse count
// - Period is delay plus pulse length
// - Gate ignored: starts on start command
// - Counts only while gate high
// - Counts only while gate low
// - Waits for gate rising edge
// - Waits for gate falling edge
// - Positive sense: delay low, pulse high
// - Negative sense: delay high, pulse low
module cptc_top #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset,
    // Avalon-MM slave
    input  wire logic [3:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [31:0]          writedata,
    input  wire logic [3:0]           byteenable,
    output logic      [31:0]          readdata,
    output logic                      waitrequest,
    // Gate and output pins
    input  wire logic                 gateIn,
    output logic                      pulseOut
);
    logic [CNT_W-1:0]     delayLoad_r;
    logic [CNT_W-1:0]     pulseLoad_r;
    logic [CNT_W-1:0]     count_r;
    logic                 outputSense_r;
    cptc_pkg::cptc_gate_t gateUsage_r;
    logic [2:0]           tbSelect_r;
    cptc_pkg::cptc_state_t state_r;
    logic                 gatePrev_r;
    logic                 ack_r;
    logic                 waitReq_r;
    logic [31:0]          readdata_r;
    logic                 pulseOut_r;
    logic                 cycleDone_r;
    logic                 startCmd;
    logic                 stopCmd;
    logic                 enable;
    logic                 busReq;
    logic [31:0]          ctrlWord;

    cptc_tick_if tb ();

    cptc_timebase u_tb (
        .clock (clock),
        .reset (reset),
        .tb    (tb.source)
    );

    assign tb.select = tbSelect_r;
    assign tb.run    = (state_r == cptc_pkg::ST_DELAY) || (state_r == cptc_pkg::ST_PULSE);

    // One wait cycle per access; answer when ack_r is set
    assign busReq      = (read || write) && !ack_r;
    assign waitrequest = waitReq_r;
    assign readdata    = readdata_r;
    assign pulseOut    = pulseOut_r;

    assign startCmd = busReq && write && (address == cptc_pkg::CTRL_OFS) && byteenable[0]
                      && writedata[cptc_pkg::CTRL_START_BIT];
    assign stopCmd  = busReq && write && (address == cptc_pkg::CTRL_OFS) && byteenable[0]
                      && writedata[cptc_pkg::CTRL_STOP_BIT];

    always_ff @(posedge clock) begin
        if (reset) begin
            ack_r     <= 1'b0;
            waitReq_r <= 1'b1;
        end else begin
            ack_r     <= busReq;
            // Registered copy keeps the pin glitch free
            waitReq_r <= !busReq;
        end
    end

    // Configuration registers
    always_ff @(posedge clock) begin
        if (reset) begin
            delayLoad_r   <= cptc_pkg::DELAY_RST[CNT_W-1:0];
            pulseLoad_r   <= cptc_pkg::PULSE_RST[CNT_W-1:0];
            outputSense_r <= 1'b0;
            gateUsage_r   <= cptc_pkg::GATE_IGNORED;
            tbSelect_r    <= 3'h0;
        end else if (busReq && write) begin
            case (address)
                cptc_pkg::CTRL_OFS: begin
                    if (byteenable[0]) begin
                        outputSense_r <= writedata[cptc_pkg::CTRL_SENSE_BIT];
                        gateUsage_r   <= cptc_pkg::cptc_gate_t'(writedata[cptc_pkg::CTRL_GATE_LSB +: 3]);
                    end
                    if (byteenable[1]) begin
                        tbSelect_r <= writedata[cptc_pkg::CTRL_TB_LSB +: 3];
                    end
                end
                cptc_pkg::DELAY_OFS: begin
                    delayLoad_r <= writedata[CNT_W-1:0];
                end
                cptc_pkg::PULSE_OFS: begin
                    pulseLoad_r <= writedata[CNT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        ctrlWord = 32'h00000000;
        ctrlWord[cptc_pkg::CTRL_SENSE_BIT] = outputSense_r;
        ctrlWord[cptc_pkg::CTRL_GATE_LSB +: 3] = gateUsage_r;
        ctrlWord[cptc_pkg::CTRL_TB_LSB +: 3] = tbSelect_r;
    end

    // Read data; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            readdata_r <= 32'h00000000;
        end else if (busReq && read) begin
            case (address)
                cptc_pkg::CTRL_OFS:   readdata_r <= ctrlWord;
                cptc_pkg::DELAY_OFS:  readdata_r <= 32'(delayLoad_r);
                cptc_pkg::PULSE_OFS:  readdata_r <= 32'(pulseLoad_r);
                cptc_pkg::STATUS_OFS: readdata_r <= {28'h0000000, cycleDone_r, state_r == cptc_pkg::ST_PULSE,
                                                     state_r};
                default:              readdata_r <= 32'h00000000;
            endcase
        end else begin
            readdata_r <= 32'h00000000;
        end
    end

    always_comb begin
        case (gateUsage_r)
            cptc_pkg::GATE_HIGH_LVL: enable = gateIn;
            cptc_pkg::GATE_LOW_LVL:  enable = !gateIn;
            default:                 enable = 1'b1;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            gatePrev_r <= 1'b0;
        end else begin
            gatePrev_r <= gateIn;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r     <= cptc_pkg::ST_IDLE;
            count_r     <= '0;
            cycleDone_r <= 1'b0;
        end else if (stopCmd) begin
            state_r <= cptc_pkg::ST_IDLE;
        end else begin
            case (state_r)
                cptc_pkg::ST_IDLE: begin
                    if (startCmd) begin
                        count_r <= delayLoad_r;
                        if (gateUsage_r == cptc_pkg::GATE_RISE_TRIG ||
                            gateUsage_r == cptc_pkg::GATE_FALL_TRIG) begin
                            state_r <= cptc_pkg::ST_ARM;
                        end else begin
                            state_r <= cptc_pkg::ST_DELAY;
                        end
                    end
                end
                cptc_pkg::ST_ARM: begin
                    if ((gateUsage_r == cptc_pkg::GATE_RISE_TRIG && gateIn && !gatePrev_r) ||
                        (gateUsage_r == cptc_pkg::GATE_FALL_TRIG && !gateIn && gatePrev_r)) begin
                        state_r <= cptc_pkg::ST_DELAY;
                    end
                end
                cptc_pkg::ST_DELAY: begin
                    if (tb.tick && enable) begin
                        if (count_r <= CNT_W'(1)) begin
                            count_r <= pulseLoad_r;
                            state_r <= cptc_pkg::ST_PULSE;
                        end else begin
                            count_r <= count_r - CNT_W'(1);
                        end
                    end
                end
                cptc_pkg::ST_PULSE: begin
                    if (tb.tick && enable) begin
                        if (count_r <= CNT_W'(1)) begin
                            count_r     <= delayLoad_r;
                            state_r     <= cptc_pkg::ST_DELAY;
                            cycleDone_r <= 1'b1;
                        end else begin
                            count_r <= count_r - CNT_W'(1);
                        end
                    end
                end
                default: begin
                    state_r <= cptc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pulseOut_r <= 1'b0;
        end else begin
            pulseOut_r <= (state_r == cptc_pkg::ST_PULSE) ^ outputSense_r;
        end
    end
endmodule

/* File: bench/cptc_chk.sv */
`timescale 1ns/1ps
module cptc_chk #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input wire logic              clock,
    input wire logic              reset,
    // Bus and pins
    input wire logic [3:0]        address,
    input wire logic              write,
    input wire logic [31:0]       writedata,
    input wire logic              waitrequest,
    input wire logic              gateIn,
    input wire logic              pulseOut
);
    logic [CNT_W-1:0] delay_r, pulse_r, len_r;
    logic [2:0]       mode_r, tb_r;
    logic             sense_r, run_r, arm_r, last_r, gPrev_r;
    logic [1:0]       edges_r;
    wire              done = write && !waitrequest;
    wire              stR = done && address == 4'h0 && writedata[0] && !writedata[1];
    wire              chg = pulseOut != last_r;
    wire              trig = (mode_r == 3'h3 && gateIn && !gPrev_r) || (mode_r == 3'h4 && !gateIn && gPrev_r);
    // First run after start is left out: its start latency is not fixed
    wire              free = run_r && mode_r == 3'h0 && tb_r == 3'h0 && edges_r != 2'h0;
    wire [CNT_W-1:0]  maxLen = (delay_r > pulse_r) ? delay_r : pulse_r;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    always_ff @(posedge clock) begin
        last_r <= pulseOut;
        gPrev_r <= gateIn;
        len_r <= chg ? 1 : len_r + 1;
        edges_r <= stR ? 2'h0 : edges_r + 2'((chg && edges_r != 2'h3) ? 1 : 0);
        if (done && address == 4'h4) delay_r <= writedata[CNT_W-1:0];
        if (done && address == 4'h8) pulse_r <= writedata[CNT_W-1:0];
        if (reset) begin
            run_r <= 1'b0;
            arm_r <= 1'b0;
            sense_r <= 1'b0;
            mode_r <= 3'h0;
            tb_r <= 3'h0;
        end else begin
            if (done && address == 4'h0) begin
                sense_r <= writedata[2];
                mode_r <= writedata[6:4];
                tb_r <= writedata[10:8];
                run_r <= writedata[1] ? 1'b0 : (writedata[0] | run_r);
            end
            arm_r <= stR ? (writedata[6:4] == 3'h3 || writedata[6:4] == 3'h4) : (arm_r && !trig && run_r);
        end
    end
    a_train_alive: assert property (free |-> len_r <= maxLen)
        else $error("output stalled while running");
    a_delay_len: assert property (free && chg && pulseOut != sense_r |-> len_r == delay_r)
        else $error("delay phase length wrong");
    a_pulse_len: assert property (free && chg && pulseOut == sense_r |-> len_r == pulse_r)
        else $error("pulse phase length wrong");
    a_free_start: assert property (stR && writedata[6:4] == 3'h0 |-> ##[2:40] pulseOut != sense_r)
        else $error("ungated start did not run");
    a_high_hold: assert property ((run_r && mode_r == 3'h1 && !gateIn)[*4] |=> $stable(pulseOut))
        else $error("counted with gate low");
    a_low_hold: assert property ((run_r && mode_r == 3'h2 && gateIn)[*4] |=> $stable(pulseOut))
        else $error("counted with gate high");
    a_trig_wait: assert property (arm_r |-> pulseOut == sense_r)
        else $error("ran before gate edge");
    a_trig_go: assert property (arm_r && trig |-> ##[2:40] pulseOut != sense_r)
        else $error("gate edge did not start");
    a_first_sense: assert property (run_r && chg && edges_r == 2'h0 |-> pulseOut != sense_r)
        else $error("pulse level wrong");
    a_stop_hold: assert property ($fell(run_r) |-> ##1 (pulseOut == sense_r)[*6])
        else $error("stop left output active");
    cover property (free && chg);
    cover property (arm_r && trig);
    cover property ($fell(run_r));
endmodule
bind cptc_top cptc_chk #(.CNT_W(CNT_W)) cptc_chk_inst (
    .clock(clock),
    .reset(reset),
    .address(address),
    .write(write),
    .writedata(writedata),
    .waitrequest(waitrequest),
    .gateIn(gateIn),
    .pulseOut(pulseOut)
);

/* File: bench/cptc_gate_model.sv */
`timescale 1ns/1ps
// Gate source, one clock behind the request like a registered driver
module cptc_gate_model (
    // Clock
    input wire logic clock,
    // Request and pin
    input wire logic level,
    output logic     gate
);
    initial gate = 1'b0;
    always @(posedge clock) begin
        gate <= level;
    end
endmodule

/* File: bench/cptc_top_test.sv */
`timescale 1ns/1ps
module cptc_top_test;
    logic        clock = 0, reset = 1, read = 0, write = 0, gateLvl = 0, s, l1, l2;
    logic [3:0]  address = 4'h0;
    logic [31:0] writedata = 32'h0, rd, readdata;
    logic        waitrequest, pulseOut, gateIn;
    int          n_mismatch = 0, cmp_count = 0, seed = 32'h755a, d, p, n1, n2;
    always #5 clock = ~clock;
    cptc_gate_model cptc_gate_model_inst (.clock(clock), .level(gateLvl), .gate(gateIn));
    cptc_top cptc_top_inst (.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .gateIn(gateIn), .pulseOut(pulseOut));
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task acc(input logic w, input logic [3:0] a, input logic [31:0] v);
        int i;
        @(posedge clock);
        address <= a;
        writedata <= v;
        write <= w;
        read <= !w;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (waitrequest !== 1'b0 && i < 50);
        if (i >= 50) begin
            n_mismatch++;
            end_of_test;
        end
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task rdchk(input logic [3:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk("register", e, rd);
    endtask
    // Length of the run in progress, bounded
    task run(output logic lv, output int n);
        lv = pulseOut;
        n = 0;
        while (pulseOut === lv && n < 300) begin
            @(posedge clock);
            n++;
        end
        if (n >= 300) begin
            n_mismatch++;
            end_of_test;
        end
    endtask
    initial begin
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        rdchk(4'h4, 32'h3);
        rdchk(4'h8, 32'h3);
        rdchk(4'hC, 32'h0);
        rdchk(4'h2, 32'h0);
        for (int m = 0; m < 5; m++) begin
            s = m[0];
            // Minimum three ticks per phase
            d = 3 + $unsigned($random(seed)) % 8;
            p = (m == 0) ? d : 3 + $unsigned($random(seed)) % 8;
            gateLvl <= (m == 2 || m == 4);
            acc(1'b1, 4'h4, d);
            acc(1'b1, 4'h8, p);
            // Timebase 0 is the finest
            acc(1'b1, 4'h0, {m[2:0], 1'b0, s, 2'b00});
            acc(1'b1, 4'h0, {m[2:0], 1'b0, s, 2'b01});
            for (int k = 0; k < 20; k++) begin
                @(posedge clock);
                if (m != 0) chk("held", s, pulseOut);
            end
            gateLvl <= (m == 1 || m == 3);
            // First run is partial, so skip it
            run(l1, n1);
            run(l1, n1);
            run(l2, n2);
            chk("pulse run", (l1 === !s) ? p : d, n1);
            chk("delay run", (l1 === !s) ? d : p, n2);
            chk("period", d + p, n1 + n2);
            chk("toggle", !l1, l2);
            acc(1'b1, 4'h0, {m[2:0], 1'b0, s, 2'b10});
            repeat (2) @(posedge clock);
            for (int k = 0; k < 8; k++) begin
                @(posedge clock);
                chk("stopped", s, pulseOut);
            end
            rdchk(4'hC, 32'h8);
            $display("test %0d done", m);
        end
        end_of_test;
    end
endmodule
